// >>> core/sdp_defs.vh
// constants for the synchronous ram port block
// What this block does
// - strobe low uses external address unless clear is low, else counter
// - strobe low loads address every clock edge
// - output state follows previous cycle controls
// - counter clear costs no cycle, accesses zero
// - advance steps address, write lands there
// - all input registers capture on rising edge
// - array write strobe is self timed
// - output enable acts without a port clock edge
// - inactive advance stalls the counter
// - deselect for one cycle powers port down
// - pipelined needs two selected cycles to drive
// - no load or advance holds address, data
// - deselect floats outputs from next edge
`ifndef SDP_DEFS_VH
`define SDP_DEFS_VH
`define SDP_ADDR_W    16
`define SDP_DATA_W    8
`define SDP_ADDR_ZERO 16'h0000
`define SDP_SYNC_RST  3'h0
`endif

// >>> core/sdp_port.v
// one synchronous dual-port ram port with burst address counter
`timescale 1ns/1ns
`include "sdp_defs.vh"
module sdp_port #(
   parameter AW = `SDP_ADDR_W,
   parameter DW = `SDP_DATA_W
) (
   input  wire          CLK_SYS_I,
   input  wire          RSTN_I,
   input  wire          PORT_CLK_I,
   input  wire [AW-1:0] ADDR_I,
   input  wire          ADDRESS_LOAD_STROBE_N_I,
   input  wire          COUNT_ADVANCE_N_I,
   input  wire          COUNT_CLEAR_N_I,
   input  wire          SELECT_ACTIVE_LOW_N_I,
   input  wire          SELECT_ACTIVE_HIGH_I,
   input  wire          READ_WRITE_N_I,
   input  wire          OUTPUT_ENABLE_N_I,
   input  wire          OUTPUT_LATENCY_SELECT_I,
   input  wire [DW-1:0] DATA_I,
   output reg  [DW-1:0] DATA_O,
   output reg           DATA_OE_N_O,
   output reg           POWER_DOWN_O,
   output reg  [AW-1:0] INT_ADDR_O
);

   // ***************************************************************
   // reset release and pin synchronisers
   // ***************************************************************
   wire          rst_n;
   wire          pclk;
   wire          load_n;
   wire          adv_n;
   wire          clr_n;
   wire          sel_lo_n;
   wire          sel_hi;
   wire          rw_n;
   wire          oe_n;
   wire          pipe;
   wire [AW-1:0] ext_adr;
   wire [DW-1:0] din;

   sdp_rst_sync u_rst (
      .clk_i    (CLK_SYS_I),
      .arst_n_i (RSTN_I),
      .rst_n_o  (rst_n)
   );

   // same depth on every pin so relative timing survives the crossing
   sdp_sync3 u_sync_pclk (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (PORT_CLK_I),
      .lvl_o   (pclk)
   );

   sdp_sync3 u_sync_load (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (ADDRESS_LOAD_STROBE_N_I),
      .lvl_o   (load_n)
   );

   sdp_sync3 u_sync_adv (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (COUNT_ADVANCE_N_I),
      .lvl_o   (adv_n)
   );

   sdp_sync3 u_sync_clr (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (COUNT_CLEAR_N_I),
      .lvl_o   (clr_n)
   );

   sdp_sync3 u_sync_sel_lo (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (SELECT_ACTIVE_LOW_N_I),
      .lvl_o   (sel_lo_n)
   );

   sdp_sync3 u_sync_sel_hi (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (SELECT_ACTIVE_HIGH_I),
      .lvl_o   (sel_hi)
   );

   sdp_sync3 u_sync_rw (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (READ_WRITE_N_I),
      .lvl_o   (rw_n)
   );

   sdp_sync3 u_sync_oe (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (OUTPUT_ENABLE_N_I),
      .lvl_o   (oe_n)
   );

   sdp_sync3 u_sync_pipe (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (OUTPUT_LATENCY_SELECT_I),
      .lvl_o   (pipe)
   );

   sdp_sync3 #(.W(AW)) u_sync_adr (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (ADDR_I),
      .lvl_o   (ext_adr)
   );

   sdp_sync3 #(.W(DW)) u_sync_din (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .pin_i   (DATA_I),
      .lvl_o   (din)
   );

   // ***************************************************************
   // port clock edge detect
   // ***************************************************************
   reg  pclk_q;
   wire rise = pclk & ~pclk_q;

   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n)
         pclk_q <= 1'b0;
      else
         pclk_q <= pclk;
   end

   // ***************************************************************
   // address select and counter
   // ***************************************************************
   wire [AW-1:0] cnt_q;
   wire [AW-1:0] acc_d;
   wire          sel = ~sel_lo_n & sel_hi;

   sdp_addr_ctr #(.AW(AW)) u_ctr (
      .clk_i    (CLK_SYS_I),
      .rst_n_i  (rst_n),
      .step_i   (rise),
      .clr_n_i  (clr_n),
      .load_n_i (load_n),
      .adv_n_i  (adv_n),
      .ext_i    (ext_adr),
      .acc_o    (acc_d),
      .cnt_o    (cnt_q)
   );

   // ***************************************************************
   // array, input registers and output pipeline
   // ***************************************************************
   reg [DW-1:0] mem [0:(1<<AW)-1];
   reg [DW-1:0] rd_q;
   reg [DW-1:0] pipe_q;
   reg          rd_en_q;
   reg          rd_en2_q;
   reg          sel_q;
   reg          wr_q;
   reg [AW-1:0] wr_adr_q;
   reg [DW-1:0] wr_dat_q;

   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         rd_q     <= {DW{1'b0}};
         pipe_q   <= {DW{1'b0}};
         rd_en_q  <= 1'b0;
         rd_en2_q <= 1'b0;
         sel_q    <= 1'b0;
         wr_q     <= 1'b0;
         wr_adr_q <= `SDP_ADDR_ZERO;
         wr_dat_q <= {DW{1'b0}};
      end else begin
         // self-timed write: one system cycle after capture
         wr_q <= 1'b0;
         if (wr_q)
            mem[wr_adr_q] <= wr_dat_q;
         if (rise) begin
            sel_q    <= sel;
            rd_en_q  <= sel & rw_n;
            // previous read edge and this edge both selected
            rd_en2_q <= rd_en_q & sel;
            rd_q     <= mem[acc_d];
            pipe_q   <= rd_q;
            wr_q     <= sel & ~rw_n;
            wr_adr_q <= acc_d;
            wr_dat_q <= din;
         end
      end
   end

   // ***************************************************************
   // outputs; enable is combined without waiting for a port edge
   // ***************************************************************
   wire drive = pipe ? rd_en2_q : rd_en_q;

   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         DATA_O       <= {DW{1'b0}};
         DATA_OE_N_O  <= 1'b1;
         POWER_DOWN_O <= 1'b1;
         INT_ADDR_O   <= `SDP_ADDR_ZERO;
      end else begin
         DATA_O       <= pipe ? pipe_q : rd_q;
         DATA_OE_N_O  <= ~(drive & ~oe_n);
         POWER_DOWN_O <= ~sel_q;
         INT_ADDR_O   <= cnt_q;
      end
   end

endmodule // sdp_port

// ***************************************************************
// three stage pin synchroniser with agreement stage
// ***************************************************************
module sdp_sync3 #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] pin_i,
   output reg  [W-1:0] lvl_o
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;

   // a bit moves only once stages two and three agree
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q  <= {W{1'b0}};
         s2_q  <= {W{1'b0}};
         s3_q  <= {W{1'b0}};
         lvl_o <= {W{1'b0}};
      end else begin
         s1_q  <= pin_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_o <= (s2_q & s3_q) | (lvl_o & (s2_q | s3_q));
      end
   end

endmodule // sdp_sync3

// ***************************************************************
// reset release
// ***************************************************************
module sdp_rst_sync (
   input  wire clk_i,
   input  wire arst_n_i,
   output wire rst_n_o
);

   reg [1:0] rst_q;

   // asserts at once, releases only on a clock edge
   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         rst_q <= 2'b00;
      else
         rst_q <= {rst_q[0], 1'b1};
   end

   assign rst_n_o = rst_q[1];

endmodule // sdp_rst_sync

// ***************************************************************
// burst address counter
// ***************************************************************
module sdp_addr_ctr #(
   parameter AW = `SDP_ADDR_W
) (
   input  wire          clk_i,
   input  wire          rst_n_i,
   input  wire          step_i,
   input  wire          clr_n_i,
   input  wire          load_n_i,
   input  wire          adv_n_i,
   input  wire [AW-1:0] ext_i,
   output reg  [AW-1:0] acc_o,
   output reg  [AW-1:0] cnt_o
);

   // the chosen address is also this edge's access, so no dead cycle
   always @* begin
      if (!clr_n_i)
         acc_o = `SDP_ADDR_ZERO;
      else if (!load_n_i)
         acc_o = ext_i;
      else if (!adv_n_i)
         acc_o = cnt_o + {{(AW-1){1'b0}}, 1'b1};
      else
         acc_o = cnt_o;
   end

   // counter moves only on a detected port edge
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         cnt_o <= `SDP_ADDR_ZERO;
      else if (step_i)
         cnt_o <= acc_o;
   end

endmodule // sdp_addr_ctr

// >>> verification/sdp_master.sv
// bus master model: makes the port clock, idle low between frames
`timescale 1ns/1ns
module sdp_master (
   input  wire logic run_i,
   output logic      pclk_o
);
   // fixed phase against the system clock: edges land 2 ns before its rise
   initial begin
      pclk_o = 1'b0;
      #3;
      forever begin
         #40;
         pclk_o = run_i ? ~pclk_o : 1'b0;
      end
   end
endmodule // sdp_master

// >>> verification/sdp_port_monitor.sv
// assertion checker for the ram port block
`timescale 1ns/1ns
module sdp_port_monitor (
   input logic        CLK_SYS_I, RSTN_I, PORT_CLK_I, OUTPUT_ENABLE_N_I,
   input logic [15:0] ADDR_I, INT_ADDR_O,
   input logic        ADDRESS_LOAD_STROBE_N_I, COUNT_ADVANCE_N_I,
   input logic        COUNT_CLEAR_N_I, SELECT_ACTIVE_LOW_N_I,
   input logic        SELECT_ACTIVE_HIGH_I, DATA_OE_N_O, POWER_DOWN_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   wire pk = PORT_CLK_I;
   wire ld = !ADDRESS_LOAD_STROBE_N_I;
   wire cn = !COUNT_ADVANCE_N_I;
   wire cl = !COUNT_CLEAR_N_I;
   wire ds = SELECT_ACTIVE_LOW_N_I | !SELECT_ACTIVE_HIGH_I;
   addr_load_a: assert property ($rose(pk) && ld && !cl
      |-> ##7 INT_ADDR_O == $past(ADDR_I, 7)) else $error("bad load");
   addr_clear_a: assert property ($rose(pk) && cl
      |-> ##7 INT_ADDR_O == 16'h0000) else $error("bad clear");
   addr_step_a: assert property ($rose(pk) && !ld && cn && !cl
      |-> ##7 INT_ADDR_O == $past(INT_ADDR_O, 7) + 16'h0001)
      else $error("bad step");
   addr_hold_a: assert property ($rose(pk) && !ld && !cn && !cl
      |-> ##7 INT_ADDR_O == $past(INT_ADDR_O, 7)) else $error("bad hold");
   addr_quiet_a: assert property (!pk [*8] |=> $stable(INT_ADDR_O))
      else $error("address moved without port edge");
   pd_desel_a: assert property ($rose(pk) && ds |-> ##7 POWER_DOWN_O)
      else $error("no power down");
   pd_float_a: assert property (POWER_DOWN_O && $past(POWER_DOWN_O)
      |-> DATA_OE_N_O) else $error("driving while deselected");
   oe_async_a: assert property (OUTPUT_ENABLE_N_I [*8] |-> DATA_OE_N_O)
      else $error("driving with enable off");
endmodule // sdp_port_monitor
bind sdp_port sdp_port_monitor u_mon (.*);

// >>> verification/tb_top.sv
// self-checking bench for the ram port block
`timescale 1ns/1ns
module tb_top;
   logic        clk, rstn, pk, run, ld_n, cen, clr, sn, sh, rw, oe, lat;
   logic        doe, pd, hi_off;
   logic [15:0] ad, ia, a [4];
   logic [7:0]  din, dout, d [4], q [$];
   int          err_count, checked;
   sdp_master u_mst (.run_i(run), .pclk_o(pk));
   sdp_port DUT (.CLK_SYS_I(clk), .RSTN_I(rstn), .PORT_CLK_I(pk),
      .ADDR_I(ad), .ADDRESS_LOAD_STROBE_N_I(ld_n), .COUNT_ADVANCE_N_I(cen),
      .COUNT_CLEAR_N_I(clr), .SELECT_ACTIVE_LOW_N_I(sn),
      .SELECT_ACTIVE_HIGH_I(sh), .READ_WRITE_N_I(rw),
      .OUTPUT_ENABLE_N_I(oe), .OUTPUT_LATENCY_SELECT_I(lat), .DATA_I(din),
      .DATA_O(dout), .DATA_OE_N_O(doe), .POWER_DOWN_O(pd), .INT_ADDR_O(ia));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task stop_test;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // inputs move at the port clock fall, well clear of the rise
   task cyc(input logic l, c, r, s, w, input logic [15:0] x,
            input logic [7:0] v);
      @(negedge pk);
      @(posedge clk);
      {ld_n, cen, clr, sn, sh, rw, ad, din} <=
         {l, c, r, s, !s & !hi_off, w, x, v};
   endtask
   // a driven output with nothing expected is a fault too
   always @(posedge pk) if (doe === 1'b0) begin
      checked++;
      if (q.size() == 0 || dout !== q[0]) begin
         err_count++;
         $display("Error %0t: read data", $time);
      end
      if (q.size() > 0) void'(q.pop_front());
   end
   initial begin
      #20000;
      err_count++;
      stop_test;
   end
   initial begin
      {rstn, run, oe, lat, hi_off} = 5'h00;
      {ld_n, cen, clr, sn, sh, rw, ad, din} = {6'b111101, 24'h00_0000};
      void'($urandom(32'h09bb_5430));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
      run <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         a[i] = {i[1:0], 6'h01, 8'($urandom)};
         d[i] = 8'($urandom);
         cyc(0, 1, 1, 0, 0, a[i], d[i]);
      end
      for (int i = 0; i < 4; i++) begin
         cyc(0, 1, 1, 0, 1, a[i], 8'h00);
         q.push_back(d[i]);
      end
      cyc(0, 1, 0, 0, 0, a[0], 8'h5a);
      cyc(1, 0, 1, 0, 0, a[0], 8'ha5);
      cyc(1, 1, 1, 0, 1, a[0], 8'h00);
      q.push_back(8'ha5);
      cyc(0, 1, 1, 0, 1, 16'h0000, 8'h00);
      q.push_back(8'h5a);
      cyc(0, 1, 1, 0, 0, 16'hffff, 8'h3c);
      cyc(1, 0, 1, 0, 0, a[0], 8'hc3);
      cyc(0, 0, 1, 0, 1, 16'h0000, 8'h00);
      q.push_back(8'hc3);
      cyc(0, 1, 1, 0, 1, 16'h0000, 8'h00);
      oe <= 1'b1;
      cyc(0, 1, 1, 1, 1, a[2], 8'h00);
      hi_off = 1'b1;
      cyc(0, 1, 1, 0, 1, a[2], 8'h00);
      hi_off = 1'b0;
      @(negedge pk);
      @(posedge clk);
      {run, oe} <= 2'b01;
      repeat (20) @(posedge clk);
      {lat, oe, run} <= 3'b101;
      repeat (4) begin
         cyc(0, 1, 1, 0, 1, a[3], 8'h00);
         q.push_back(d[3]);
      end
      repeat (3) cyc(0, 1, 1, 1, 1, a[3], 8'h00);
      q.delete();
      stop_test;
   end
endmodule // tb_top
